/* logic/iwd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Every instruction is one 14-bit word, an opcode part plus operand parts.
// - Words fall into byte-oriented, bit-oriented and literal/control groups with their own layouts.
// - In byte operations a target bit of 0 sends the result to the accumulator, 1 to the selected register.
// - The register select is a seven-bit address from 0x00 to 0x7f.
// - In bit operations the position picks one bit of the addressed 8-bit register.
// - Literals are eight bits for data and eleven bits for jump and call targets.
// - Don't-care bits of the literal selector are ignored in the sub-op; the raw bits still reach the position and jump-target fields.
// - An instruction takes one cycle, or two with a no-op second cycle when a test succeeds or the PC changes.
// - Each instruction cycle is four oscillator periods.
module iwd_decoder (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [13:0] i_word,
   input wire logic i_branch_taken,
   output logic o_fetch,
   output logic o_cycle_end,
   output logic [1:0] o_phase,
   output logic o_valid,
   output logic o_flush,
   output iwd_pkg::iwd_group_t o_group,
   output logic [1:0] o_opcode,
   output logic [3:0] o_sub_op,
   output logic o_to_register,
   output logic o_to_accum,
   output logic [6:0] o_reg_select_num,
   output logic [2:0] o_position_in_register,
   output logic [7:0] o_bit_mask,
   output logic [7:0] o_immediate_value,
   output logic [10:0] o_jump_target,
   output logic o_is_jump,
   output logic o_may_take_two
);
   // Bit-select decode, one-hot
   function automatic logic [7:0] bit_onehot(input logic [2:0] pos);
      bit_onehot = 8'h01 << pos;
   endfunction

   logic cyc_end;
   logic [1:0] phase;

   iwd_phase_gen u_phase (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .o_phase(phase),
      .o_cycle_end(cyc_end)
   );

   iwd_pkg::iwd_state_t state;
   iwd_pkg::iwd_state_t next_state;
   logic [13:0] word;
   logic [13:0] next_word;
   logic valid;
   logic next_valid;
   iwd_pkg::iwd_group_t grp;
   iwd_pkg::iwd_group_t next_grp;
   logic [3:0] sub_op;
   logic [3:0] next_sub_op;
   logic to_reg;
   logic next_to_reg;
   logic [6:0] reg_sel;
   logic [6:0] next_reg_sel;
   logic [2:0] pos;
   logic [2:0] next_pos;
   logic [7:0] mask;
   logic [7:0] next_mask;
   logic [7:0] imm;
   logic [7:0] next_imm;
   logic [10:0] tgt;
   logic [10:0] next_tgt;
   logic jump;
   logic next_jump;
   logic two;
   logic next_two;
   logic [1:0] opc;

   assign opc = i_word[iwd_pkg::OPC_MSB:iwd_pkg::OPC_LSB];

   always_comb begin
      next_state = state;
      next_word = word;
      next_valid = valid;
      next_grp = grp;
      next_sub_op = sub_op;
      next_to_reg = to_reg;
      next_reg_sel = reg_sel;
      next_pos = pos;
      next_mask = mask;
      next_imm = imm;
      next_tgt = tgt;
      next_jump = jump;
      next_two = two;
      if (cyc_end) begin
         case (state)
            iwd_pkg::IWD_ST_EXEC: begin
               // Second cycle of a taken test or PC change runs as a no-op
               if (valid && i_branch_taken) begin
                  next_state = iwd_pkg::IWD_ST_FLUSH;
                  next_valid = 1'b0;
               end else begin
                  next_valid = 1'b1;
               end
            end
            iwd_pkg::IWD_ST_FLUSH: begin
               next_state = iwd_pkg::IWD_ST_EXEC;
               next_valid = 1'b1;
            end
            default: begin
               next_state = iwd_pkg::IWD_ST_EXEC;
               next_valid = 1'b0;
            end
         endcase
         next_word = i_word;
         next_to_reg = 1'b0;
         next_reg_sel = i_word[6:0];
         next_pos = i_word[iwd_pkg::POS_MSB:iwd_pkg::POS_LSB];
         next_mask = 8'h00;
         next_imm = i_word[7:0];
         next_tgt = i_word[10:0];
         next_jump = 1'b0;
         next_two = 1'b0;
         next_sub_op = i_word[11:8];
         case (opc)
            iwd_pkg::GRP_BYTE: begin
               next_grp = iwd_pkg::IWD_GRP_BYTE;
               next_to_reg = i_word[iwd_pkg::TGT_BIT];
               // Skip-if-zero, return and return-from-interrupt
               next_two = (i_word[11:8] == 4'hb) || (i_word[11:8] == 4'hf) || (i_word[11:1] == 11'h004);
            end
            iwd_pkg::GRP_BIT: begin
               next_grp = iwd_pkg::IWD_GRP_BIT;
               next_sub_op = {2'h0, i_word[11:10]};
               next_mask = bit_onehot(i_word[iwd_pkg::POS_MSB:iwd_pkg::POS_LSB]);
               next_two = i_word[11]; // Bit tests may skip
            end
            iwd_pkg::GRP_JUMP: begin
               next_grp = iwd_pkg::IWD_GRP_LIT;
               next_sub_op = {3'h0, i_word[iwd_pkg::JUMP_SEL_BIT]};
               next_jump = 1'b1;
               next_two = 1'b1;
            end
            iwd_pkg::GRP_LIT: begin
               next_grp = iwd_pkg::IWD_GRP_LIT;
               // Don't-care low bits of the selector are dropped
               casez (i_word[11:8])
                  4'b00??: next_sub_op = 4'h0;
                  4'b01??: next_sub_op = 4'h4;
                  4'b111?: next_sub_op = 4'he;
                  4'b110?: next_sub_op = 4'hc;
                  default: next_sub_op = i_word[11:8];
               endcase
               next_two = (i_word[11:10] == 2'h1);
            end
            default: begin
               next_grp = iwd_pkg::IWD_GRP_LIT;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= iwd_pkg::IWD_ST_EXEC;
         word <= 14'h0000;
         valid <= 1'b0;
         grp <= iwd_pkg::IWD_GRP_BYTE;
         sub_op <= 4'h0;
         to_reg <= 1'b0;
         reg_sel <= 7'h00;
         pos <= 3'h0;
         mask <= 8'h00;
         imm <= 8'h00;
         tgt <= 11'h000;
         jump <= 1'b0;
         two <= 1'b0;
      end else begin
         state <= next_state;
         word <= next_word;
         valid <= next_valid;
         grp <= next_grp;
         sub_op <= next_sub_op;
         to_reg <= next_to_reg;
         reg_sel <= next_reg_sel;
         pos <= next_pos;
         mask <= next_mask;
         imm <= next_imm;
         tgt <= next_tgt;
         jump <= next_jump;
         two <= next_two;
      end
   end

   assign o_fetch = cyc_end;
   assign o_cycle_end = cyc_end;
   assign o_phase = phase;
   assign o_valid = valid;
   assign o_flush = (state == iwd_pkg::IWD_ST_FLUSH);
   assign o_group = grp;
   assign o_opcode = word[iwd_pkg::OPC_MSB:iwd_pkg::OPC_LSB];
   assign o_sub_op = sub_op;
   assign o_to_register = valid && (grp == iwd_pkg::IWD_GRP_BYTE) && to_reg;
   assign o_to_accum = valid && (grp == iwd_pkg::IWD_GRP_BYTE) && !to_reg;
   assign o_reg_select_num = reg_sel;
   assign o_position_in_register = pos;
   assign o_bit_mask = mask;
   assign o_immediate_value = imm;
   assign o_jump_target = tgt;
   assign o_is_jump = jump;
   assign o_may_take_two = two;
endmodule // iwd_decoder
`default_nettype wire

/* logic/iwd_phase_gen.sv */
`timescale 1ns/10ps
`default_nettype none
// Divides the oscillator into instruction cycles
module iwd_phase_gen (
   input wire logic i_clk,
   input wire logic i_rst_n,
   output logic [1:0] o_phase,
   output logic o_cycle_end
);
   logic [1:0] phase;
   logic [1:0] next_phase;

   always_comb begin
      next_phase = (phase == iwd_pkg::PHASE_LAST) ? iwd_pkg::PHASE_RST : phase + 2'h1;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         phase <= iwd_pkg::PHASE_RST;
      end else begin
         phase <= next_phase;
      end
   end

   assign o_phase = phase;
   assign o_cycle_end = (phase == iwd_pkg::PHASE_LAST);
endmodule // iwd_phase_gen
`default_nettype wire

/* logic/iwd_pkg.sv */
package iwd_pkg;
   // Word layout
   localparam int WORD_W = 14;
   localparam int REG_ADDR_W = 7;
   localparam int BITPOS_W = 3;
   localparam int LIT_W = 8;
   localparam int TARGET_W = 11;
   localparam int OPC_MSB = 13;
   localparam int OPC_LSB = 12;
   localparam int TGT_BIT = 7;
   localparam int POS_MSB = 9;
   localparam int POS_LSB = 7;
   localparam int JUMP_SEL_BIT = 11;
   // Group codes in bits 13:12
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JUMP = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;
   // Timing
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PHASE_RST = 2'h0;

   typedef enum logic [1:0] {
      IWD_GRP_BYTE = 2'b00,
      IWD_GRP_BIT = 2'b01,
      IWD_GRP_LIT = 2'b10
   } iwd_group_t;

   typedef enum logic [0:0] {
      IWD_ST_EXEC = 1'b0,
      IWD_ST_FLUSH = 1'b1
   } iwd_state_t;
endpackage : iwd_pkg

/* verif/iwd_decoder_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module iwd_decoder_monitor (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_branch_taken,
   input wire logic o_fetch,
   input wire logic o_cycle_end,
   input wire logic [1:0] o_phase,
   input wire logic o_valid,
   input wire logic o_flush,
   input wire iwd_pkg::iwd_group_t o_group,
   input wire logic [1:0] o_opcode,
   input wire logic [3:0] o_sub_op,
   input wire logic o_to_register,
   input wire logic o_to_accum,
   input wire logic [6:0] o_reg_select_num,
   input wire logic [2:0] o_position_in_register,
   input wire logic [7:0] o_bit_mask,
   input wire logic [7:0] o_immediate_value,
   input wire logic [10:0] o_jump_target,
   input wire logic o_is_jump,
   input wire logic o_may_take_two
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_flush_run;
      o_flush [*4];
   endsequence
   sequence s_taken;
      o_fetch && i_branch_taken && o_valid;
   endsequence
   chk_fetch_phase: assert property (o_fetch == (o_phase == iwd_pkg::PHASE_LAST))
      else $error("fetch strobe outside last phase");
   chk_phase_step: assert property (o_phase != iwd_pkg::PHASE_LAST |=> o_phase == $past(o_phase) + 2'h1)
      else $error("phase did not advance");
   chk_fields_hold: assert property (o_phase != iwd_pkg::PHASE_LAST |=>
      $stable({o_valid, o_opcode, o_reg_select_num, o_immediate_value, o_jump_target})) else $error("fields moved");
   chk_flush_len: assert property ($rose(o_flush) |-> s_flush_run ##1 !o_flush)
      else $error("flush cycle length wrong");
   chk_branch_flush: assert property (s_taken |=> o_flush && !o_valid)
      else $error("no flush after taken branch");
   chk_plain_run: assert property (o_fetch && !i_branch_taken |=> !o_flush)
      else $error("flush without branch");
   chk_target_sel: assert property (o_valid |-> !(o_to_register && o_to_accum) &&
      ((o_to_register || o_to_accum) == (o_group == iwd_pkg::IWD_GRP_BYTE))) else $error("bad target select");
   chk_mask_pos: assert property (o_group == iwd_pkg::IWD_GRP_BIT |->
      o_bit_mask == 8'h01 << o_position_in_register) else $error("bit mask mismatch");
   chk_jump_grp: assert property (o_is_jump |-> o_opcode == 2'h2 && o_group == iwd_pkg::IWD_GRP_LIT)
      else $error("jump flag in wrong group");
   chk_cycle_end: assert property (o_cycle_end == o_fetch)
      else $error("cycle end differs from fetch strobe");
   chk_jump_two: assert property (o_is_jump |-> o_may_take_two)
      else $error("jump not marked two-cycle");
   chk_lit_dont_care: assert property (o_opcode == 2'h3 |->
      (o_sub_op[3] || o_sub_op[1:0] == 2'h0) && (o_sub_op[3:2] != 2'h3 || !o_sub_op[0])) else $error("literal x bits leaked");
endmodule // iwd_decoder_monitor
bind iwd_decoder iwd_decoder_monitor u_mon (
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_branch_taken(i_branch_taken),
   .o_fetch(o_fetch),
   .o_cycle_end(o_cycle_end),
   .o_phase(o_phase),
   .o_valid(o_valid),
   .o_flush(o_flush),
   .o_group(o_group),
   .o_opcode(o_opcode),
   .o_sub_op(o_sub_op),
   .o_to_register(o_to_register),
   .o_to_accum(o_to_accum),
   .o_reg_select_num(o_reg_select_num),
   .o_position_in_register(o_position_in_register),
   .o_bit_mask(o_bit_mask),
   .o_immediate_value(o_immediate_value),
   .o_jump_target(o_jump_target),
   .o_is_jump(o_is_jump),
   .o_may_take_two(o_may_take_two)
);
`default_nettype wire

/* verif/iwd_fetch_model.sv */
`timescale 1ns/10ps
`default_nettype none
module iwd_fetch_model (
   input wire logic i_fetch,
   input wire logic [13:0] i_next,
   input wire logic i_take,
   output logic [13:0] o_word,
   output logic o_taken
);
   // Released bus shows inverted last value
   assign o_word = i_fetch ? i_next : ~i_next;
   assign o_taken = i_fetch ? i_take : ~i_take;
endmodule // iwd_fetch_model
`default_nettype wire

/* verif/test_instruction_word_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_instruction_word_decoder;
   typedef struct packed {logic fl; logic [13:0] w;} iwd_note_t;
   localparam logic [13:0] RSV = 14'h0060;
   logic i_clk = 1'b0, i_rst_n = 1'b0, take = 1'b0, last_fl = 1'b1;
   logic i_branch_taken, o_fetch, o_cycle_end, o_valid, o_flush, o_to_register, o_to_accum, o_is_jump, o_may_take_two;
   logic [1:0] o_phase, o_opcode;
   logic [3:0] o_sub_op;
   logic [6:0] o_reg_select_num;
   logic [2:0] o_position_in_register;
   logic [7:0] o_bit_mask, o_immediate_value;
   logic [10:0] o_jump_target;
   iwd_pkg::iwd_group_t o_group;
   logic [13:0] i_word, nxt = 14'h0;
   logic [31:0] seed = 32'h3770, tmp;
   int fail_count = 0, total_checks = 0;
   iwd_note_t q[$], n;
   logic [44:0] fld;
   int k = 0;
   // Return, return-from-interrupt and literal words with don't-care bits set
   localparam logic [13:0] DIR [6] = '{14'h0008, 14'h0009, 14'h3fa5, 14'h33a5, 14'h37a5, 14'h3da5};
   always #2 i_clk = ~i_clk;
   iwd_decoder uut (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_word(i_word),
      .i_branch_taken(i_branch_taken),
      .o_fetch(o_fetch),
      .o_cycle_end(o_cycle_end),
      .o_phase(o_phase),
      .o_valid(o_valid),
      .o_flush(o_flush),
      .o_group(o_group),
      .o_opcode(o_opcode),
      .o_sub_op(o_sub_op),
      .o_to_register(o_to_register),
      .o_to_accum(o_to_accum),
      .o_reg_select_num(o_reg_select_num),
      .o_position_in_register(o_position_in_register),
      .o_bit_mask(o_bit_mask),
      .o_immediate_value(o_immediate_value),
      .o_jump_target(o_jump_target),
      .o_is_jump(o_is_jump),
      .o_may_take_two(o_may_take_two)
   );
   iwd_fetch_model u_far (.i_fetch(o_fetch), .i_next(nxt), .i_take(take), .o_word(i_word), .o_taken(i_branch_taken));
   function automatic logic [44:0] exp_f(input logic [13:0] w);
      logic by, bi, jp;
      by = w[13:12] == iwd_pkg::GRP_BYTE;
      bi = w[13:12] == iwd_pkg::GRP_BIT;
      jp = w[13:12] == iwd_pkg::GRP_JUMP;
      return {by ? 2'h0 : bi ? 2'h1 : 2'h2, w[13:12], by & w[7], by & ~w[7], w[6:0], w[9:7],
         bi ? 8'h01 << w[9:7] : 8'h00, w[7:0], w[10:0], jp,
         (by & (w[11:8] == 4'hb || w[11:8] == 4'hf)) | (bi & w[11]) | jp | (w[13:10] == 4'hd) | (w[13:1] == 13'h4)};
   endfunction
   // Selector with literal don't-care bits cleared
   function automatic logic [3:0] exp_sub(input logic [13:0] w);
      case (w[13:12])
         2'h0: return w[11:8];
         2'h1: return {2'h0, w[11:10]};
         2'h2: return {3'h0, w[11]};
         default: return !w[11] ? {w[11:10], 2'h0} : w[10] ? {w[11:9], 1'b0} : w[11:8];
      endcase
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic summarize();
      if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge i_clk);
      i_rst_n = 1'b1;
      `CHK("reset", 4'h0, {o_valid, o_flush, o_phase})
      repeat (300) begin
         @(negedge i_clk);
         while (o_fetch !== 1'b1) @(negedge i_clk);
         seed = xs(seed);
         tmp = seed;
         nxt = (k < 6) ? DIR[k] : (tmp[13:3] == RSV[13:3]) ? 14'h0 : tmp[13:0];
         take = k > 5 && !last_fl && tmp[20:19] == 2'h0;
         q.push_back({take, nxt});
         last_fl = take;
         k++;
      end
      repeat (8) @(negedge i_clk);
      summarize();
   end
   always @(negedge i_clk) begin
      if (i_rst_n && o_phase === 2'h0 && q.size() > 0) begin
         n = q.pop_front();
         fld = {o_group, o_opcode, o_to_register, o_to_accum, o_reg_select_num, o_position_in_register, o_bit_mask,
            o_immediate_value, o_jump_target, o_is_jump, o_may_take_two};
         `CHK("state", {!n.fl, n.fl}, {o_valid, o_flush})
         if (!n.fl) `CHK("fields", exp_f(n.w), fld)
         if (!n.fl) `CHK("sub_op", exp_sub(n.w), o_sub_op)
      end
   end
   initial begin
      #20000;
      fail_count++;
      summarize();
   end
endmodule // test_instruction_word_decoder
`default_nettype wire
